// >>> core/lprof_map.svh
// Purpose: register offsets, field positions and reset values of the profiler controls
// Assumes: included by the profiler control files and their bench
// Notes: definitions only
`ifndef LPROF_MAP_SVH
`define LPROF_MAP_SVH
// ****************************************
// register numbers
// ****************************************
`define LPROF_CBADDR_NUM 32'hc0000106
`define LPROF_CFG_NUM 32'hc0000105
// ****************************************
// configuration fields
// ****************************************
`define LPROF_CFG_VAL_BIT 1
`define LPROF_CFG_EVT_LO 1
`define LPROF_CFG_EVT_HI 6
`define LPROF_CFG_CONTINUOUS_SELECT_BIT 29
`define LPROF_CFG_TS_BIT 30
`define LPROF_CFG_INT_BIT 31
`define LPROF_CFG_TAG_LO 32
`define LPROF_CFG_TAG_HI 39
`define LPROF_CFG_VEC_LO 40
`define LPROF_CFG_VEC_HI 47
`define LPROF_CFG_WMASK 64'h0000_ffff_e000_007e
`define LPROF_CFG_RESET 64'h0
`define LPROF_CBADDR_RESET 64'h0
`define LPROF_XMASK_BIT 62
`endif

// >>> core/lprof_pkg.sv
// Purpose: shared types of the profiler controls
// Assumes: nothing
// Notes: numbers live in lprof_map.svh
package lprof_pkg;
  typedef enum logic [1:0] {
    LPROF_OP_LOAD,
    LPROF_OP_STORE,
    LPROF_OP_INSERT,
    LPROF_OP_VALUE
  } lprof_op_t;
  typedef enum {
    LPROF_IDLE,
    LPROF_RUN
  } lprof_state_t;
endpackage

// >>> core/lprof_insn_gate.sv
// Purpose: decides whether a profiling instruction may run
// Assumes: inputs on the core clock
// Notes: one registered decision per request
`timescale 1ns/1ns
`include "lprof_map.svh"
module lprof_insn_gate
  import lprof_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic supported_i,
  input wire logic [63:0] xmask_i,
  output logic ok_o,
  output logic ud_o
);
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ok_o <= 1'b0;
      ud_o <= 1'b0;
    end
    else
    begin
      ok_o <= req_i && supported_i && xmask_i[`LPROF_XMASK_BIT];
      ud_o <= req_i && !(supported_i && xmask_i[`LPROF_XMASK_BIT]);
    end
  end

  chk_gate_blocks: assert property (@(posedge mclk_i) disable iff (rst_i)
    req_i && !xmask_i[`LPROF_XMASK_BIT] |=> ud_o && !ok_o)
    else $error("gate let an instruction through with the feature off");
endmodule // lprof_insn_gate

// >>> core/lprof_ctrl.sv
// Purpose: profiler configuration and control-block address registers, instruction control
// Assumes: model register accesses and instruction requests are one-cycle pulses on mclk_i
// Notes: memory work of the instructions lives in the core; this block issues the orders
//
// Functional notes
// - config bit 29 picks continuous mode; clear means synchronized mode.
// - bit 30 with timestamp counter present stamps records with the counter.
// - bit 31 allows threshold interrupt; clear suppresses it.
// - bits 39:32 give the core tag copied into every record.
// - address register sits at number c0000106 and shows internal address.
// - reading the address register has no side effect.
// - nonzero write to address register faults; only load or restore set it.
// - writing zero stops profiling at once and drops state unsaved.
// - control-block accesses use the stored linear address, no segment base.
// - address register resets to zero so profiling starts disabled.
// - all four instructions fault invalid-opcode when feature missing or mask bit clear.
// - load instruction enables or disables profiling and sets the events.
// - store instruction reports current profiling state.
// - insert instruction stores one record whenever profiling is running.
// - value instruction counts and stores only at the programmed interval.
// - configuration register resets to zero.
`timescale 1ns/1ns
`include "lprof_map.svh"
module lprof_ctrl
  import lprof_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic msr_rd_i,
  input wire logic msr_wr_i,
  input wire logic [31:0] msr_num_i,
  input wire logic [63:0] msr_wdata_i,
  output logic [63:0] msr_rdata_o,
  output logic msr_ack_o,
  output logic gp_fault_o,
  input wire logic supported_i,
  input wire logic ts_present_i,
  input wire logic [63:0] xmask_i,
  input wire logic insn_req_i,
  input wire lprof_op_t insn_op_i,
  input wire logic [63:0] insn_addr_i,
  input wire logic [63:0] ds_base_i,
  input wire logic [6:1] insn_events_i,
  input wire logic [31:0] val_interval_i,
  input wire logic [31:0] val_counter_i,
  input wire logic restore_i,
  input wire logic [63:0] restore_addr_i,
  input wire logic [63:0] tsc_i,
  output logic ud_fault_o,
  output logic insn_done_o,
  output logic [63:0] insn_result_o,
  output logic active_o,
  output logic [6:1] events_o,
  output logic [63:0] cb_linear_o,
  output logic discard_o,
  output logic rec_store_o,
  output logic [7:0] rec_tag_o,
  output logic [63:0] rec_stamp_o,
  output logic continuous_o,
  output logic thr_int_en_o,
  output logic [7:0] thr_vector_o
);
  logic [63:0] cfg;
  logic [63:0] cbaddr;
  logic [31:0] val_count;
  logic gate_ok;
  logic gate_ud;
  logic op_req;
  lprof_op_t op_q;
  logic [63:0] addr_q;
  logic [63:0] next_cbaddr;
  lprof_state_t state;
  logic cfg_hit;
  logic cb_hit;

  assign cfg_hit = msr_num_i == `LPROF_CFG_NUM;
  assign cb_hit = msr_num_i == `LPROF_CBADDR_NUM;

  // ****************************************
  // instruction gating
  // ****************************************
  lprof_insn_gate lprof_insn_gate_i (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .req_i(insn_req_i),
    .supported_i(supported_i),
    .xmask_i(xmask_i),
    .ok_o(gate_ok),
    .ud_o(gate_ud)
  );

  // operands held one cycle to line up with the gate decision
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      op_q <= LPROF_OP_LOAD;
      addr_q <= 64'h0;
    end
    else if (insn_req_i)
    begin
      op_q <= insn_op_i;
      addr_q <= insn_addr_i;
    end
  end
  assign op_req = gate_ok;

  // ****************************************
  // configuration register
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cfg <= `LPROF_CFG_RESET;
    else if (msr_wr_i && cfg_hit)
      cfg <= msr_wdata_i & `LPROF_CFG_WMASK;
  end

  // ****************************************
  // control-block address
  // ****************************************
  // linear form: segment base added once at load, never on later use
  always_comb
  begin
    next_cbaddr = cbaddr;
    if (msr_wr_i && cb_hit && msr_wdata_i == 64'h0)
      next_cbaddr = 64'h0;
    else if (restore_i)
      next_cbaddr = restore_addr_i;
    else if (op_req && op_q == LPROF_OP_LOAD)
      next_cbaddr = (addr_q == 64'h0) ? 64'h0 : addr_q + ds_base_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cbaddr <= `LPROF_CBADDR_RESET;
    else
      cbaddr <= next_cbaddr;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      state <= LPROF_IDLE;
    else if (next_cbaddr == 64'h0)
      state <= LPROF_IDLE;
    else
      state <= LPROF_RUN;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      events_o <= 6'h0;
    else if (msr_wr_i && cb_hit && msr_wdata_i == 64'h0)
      events_o <= 6'h0;
    else if (op_req && op_q == LPROF_OP_LOAD)
      events_o <= (addr_q == 64'h0) ? 6'h0 : insn_events_i;
  end

  // ****************************************
  // model register port
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      msr_rdata_o <= 64'h0;
      msr_ack_o <= 1'b0;
      gp_fault_o <= 1'b0;
    end
    else
    begin
      msr_ack_o <= (msr_rd_i || msr_wr_i) && (cfg_hit || cb_hit);
      gp_fault_o <= (msr_wr_i && cb_hit && msr_wdata_i != 64'h0)
        || ((msr_rd_i || msr_wr_i) && !cfg_hit && !cb_hit);
      if (msr_rd_i && cb_hit)
        msr_rdata_o <= cbaddr;
      else if (msr_rd_i && cfg_hit)
        msr_rdata_o <= cfg;
      else if (msr_rd_i)
        msr_rdata_o <= 64'h0;
    end
  end

  // ****************************************
  // instruction results and records
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      val_count <= 32'h0;
    else if (op_req && op_q == LPROF_OP_LOAD)
      val_count <= val_counter_i;
    else if (op_req && op_q == LPROF_OP_VALUE && state == LPROF_RUN
             && cfg[`LPROF_CFG_VAL_BIT])
      val_count <= (val_count == 32'h0 || val_count[31]) ? val_interval_i
        : val_count - 32'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ud_fault_o <= 1'b0;
      insn_done_o <= 1'b0;
      insn_result_o <= 64'h0;
      rec_store_o <= 1'b0;
      rec_tag_o <= 8'h0;
      rec_stamp_o <= 64'h0;
      discard_o <= 1'b0;
    end
    else
    begin
      ud_fault_o <= gate_ud;
      insn_done_o <= op_req;
      discard_o <= msr_wr_i && cb_hit && msr_wdata_i == 64'h0;
      if (op_req && op_q == LPROF_OP_STORE)
        insn_result_o <= (cbaddr == 64'h0) ? 64'h0 : cbaddr - ds_base_i;
      rec_store_o <= op_req && state == LPROF_RUN
        && (op_q == LPROF_OP_INSERT
        || (op_q == LPROF_OP_VALUE && cfg[`LPROF_CFG_VAL_BIT]
        && (val_count == 32'h0 || val_count[31])));
      rec_tag_o <= cfg[`LPROF_CFG_TAG_HI:`LPROF_CFG_TAG_LO];
      rec_stamp_o <= (cfg[`LPROF_CFG_TS_BIT] && ts_present_i) ? tsc_i : 64'h0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      active_o <= 1'b0;
      cb_linear_o <= 64'h0;
      continuous_o <= 1'b0;
      thr_int_en_o <= 1'b0;
      thr_vector_o <= 8'h0;
    end
    else
    begin
      active_o <= next_cbaddr != 64'h0;
      cb_linear_o <= next_cbaddr;
      continuous_o <= cfg[`LPROF_CFG_CONTINUOUS_SELECT_BIT];
      thr_int_en_o <= cfg[`LPROF_CFG_INT_BIT];
      thr_vector_o <= cfg[`LPROF_CFG_VEC_HI:`LPROF_CFG_VEC_LO];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_nonzero_write_faults: assert property (@(posedge mclk_i) disable iff (rst_i)
    msr_wr_i && cb_hit && msr_wdata_i != 64'h0 |=> gp_fault_o && cbaddr == $past(cbaddr))
    else $error("nonzero address write did not fault");
  chk_zero_write_stops: assert property (@(posedge mclk_i) disable iff (rst_i)
    msr_wr_i && cb_hit && msr_wdata_i == 64'h0 |=> cbaddr == 64'h0 && discard_o ##1 !active_o)
    else $error("zero write did not stop profiling");
  chk_read_no_effect: assert property (@(posedge mclk_i) disable iff (rst_i)
    msr_rd_i && cb_hit && !msr_wr_i && !restore_i && !op_req
    |=> msr_rdata_o == $past(cbaddr) && $stable(cbaddr))
    else $error("address read had a side effect");
  chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cfg & ~`LPROF_CFG_WMASK) == 64'h0)
    else $error("reserved config bits set");
  chk_reset_zero: assert property (@(posedge mclk_i)
    $fell(rst_i) |-> cbaddr == 64'h0 && cfg == 64'h0 && !active_o)
    else $error("registers not zero after reset");
  chk_continuous_select_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 continuous_o == $past(cfg[`LPROF_CFG_CONTINUOUS_SELECT_BIT]))
    else $error("continuous select mismatch");
  chk_int_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cfg[`LPROF_CFG_INT_BIT] |=> !thr_int_en_o)
    else $error("threshold interrupt allowed while bit clear");
  chk_ud_blocks: assert property (@(posedge mclk_i) disable iff (rst_i)
    insn_req_i && !supported_i |-> ##2 ud_fault_o && !insn_done_o && !rec_store_o)
    else $error("unsupported instruction not refused");
  chk_insert_stores: assert property (@(posedge mclk_i) disable iff (rst_i)
    op_req && op_q == LPROF_OP_INSERT && state == LPROF_RUN |=> rec_store_o)
    else $error("insert did not store a record");
  // tag reaches records two cycles after the config write
  chk_tag_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
    msr_wr_i && cfg_hit
    |=> ##1 rec_tag_o == $past(msr_wdata_i[`LPROF_CFG_TAG_HI:`LPROF_CFG_TAG_LO], 2))
    else $error("core tag not carried into records");
  chk_stamp_gated: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cfg[`LPROF_CFG_TS_BIT] || !ts_present_i |=> rec_stamp_o == 64'h0)
    else $error("stamp written without counter or enable");
  // restore and zero write win over load, so both are left out here
  chk_load_enables: assert property (@(posedge mclk_i) disable iff (rst_i)
    op_req && op_q == LPROF_OP_LOAD && addr_q != 64'h0 && !restore_i
    && !(msr_wr_i && cb_hit && msr_wdata_i == 64'h0)
    |=> active_o && events_o == $past(insn_events_i))
    else $error("load did not enable profiling");
  chk_store_idle_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    op_req && op_q == LPROF_OP_STORE && cbaddr == 64'h0 |=> insn_result_o == 64'h0)
    else $error("store reported an address while disabled");
  chk_linear_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
    op_req && op_q != LPROF_OP_LOAD && !restore_i && !msr_wr_i |=> cb_linear_o == $past(cbaddr))
    else $error("linear address moved outside a load");
  chk_value_skips: assert property (@(posedge mclk_i) disable iff (rst_i)
    op_req && op_q == LPROF_OP_VALUE && val_count != 32'h0 && !val_count[31]
    |=> !rec_store_o)
    else $error("value sample stored before its interval");
  chk_unmapped_faults: assert property (@(posedge mclk_i) disable iff (rst_i)
    (msr_rd_i || msr_wr_i) && !cfg_hit && !cb_hit |=> gp_fault_o && !msr_ack_o)
    else $error("unmapped register number not refused");
endmodule // lprof_ctrl

// >>> test/lprof_ctrl_tb.sv
// Purpose: self-checking bench for the profiler control registers and instruction control
// Assumes: registered outputs settle one cycle after the taking edge, instructions two
// Notes: inputs change on the falling edge; one idle cycle before each request
`timescale 1ns/1ns
`include "lprof_map.svh"
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module lprof_ctrl_tb
  import lprof_pkg::*;
;
  typedef struct {logic [63:0] w; logic [63:0] e;} lprof_row_t;
  logic mclk_i, rst_i, msr_rd_i, msr_wr_i, supported_i, ts_present_i, insn_req_i, restore_i;
  logic [31:0] msr_num_i, val_interval_i, val_counter_i;
  logic [63:0] msr_wdata_i, xmask_i, insn_addr_i, ds_base_i, restore_addr_i, tsc_i;
  lprof_op_t insn_op_i;
  logic [6:1] insn_events_i, events_o;
  logic [63:0] msr_rdata_o, insn_result_o, cb_linear_o, rec_stamp_o;
  logic msr_ack_o, gp_fault_o, ud_fault_o, insn_done_o, active_o, discard_o, rec_store_o;
  logic continuous_o, thr_int_en_o;
  logic [7:0] rec_tag_o, thr_vector_o;
  int num_errors, samples_checked, cycles;
  lprof_row_t rows[4];

  lprof_ctrl lprof_ctrl_i (.mclk_i, .rst_i, .msr_rd_i, .msr_wr_i, .msr_num_i, .msr_wdata_i,
    .msr_rdata_o, .msr_ack_o, .gp_fault_o, .supported_i, .ts_present_i, .xmask_i,
    .insn_req_i, .insn_op_i, .insn_addr_i, .ds_base_i, .insn_events_i, .val_interval_i,
    .val_counter_i, .restore_i, .restore_addr_i, .tsc_i, .ud_fault_o, .insn_done_o,
    .insn_result_o, .active_o, .events_o, .cb_linear_o, .discard_o, .rec_store_o,
    .rec_tag_o, .rec_stamp_o, .continuous_o, .thr_int_en_o, .thr_vector_o);

  // ********************************
  // clock, timeout, closing
  // ********************************
  initial
  begin
    mclk_i = 1'h0;
    forever #20 mclk_i = ~mclk_i;
  end

  // whole run needs about a hundred cycles
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      num_errors++;
      conclude();
    end
  end

  task conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ********************************
  // request tasks
  // ********************************
  // idle cycle first so no strobe is set twice in one time step
  task msr(input logic rd, input logic wr, input logic [31:0] num, input logic [63:0] d);
    @(negedge mclk_i);
    msr_rd_i = rd;
    msr_wr_i = wr;
    msr_num_i = num;
    msr_wdata_i = d;
    @(negedge mclk_i);
    msr_rd_i = 1'h0;
    msr_wr_i = 1'h0;
  endtask

  task insn(input lprof_op_t op, input logic [63:0] a);
    @(negedge mclk_i);
    insn_op_i = op;
    insn_addr_i = a;
    insn_req_i = 1'h1;
    @(negedge mclk_i);
    insn_req_i = 1'h0;
    @(negedge mclk_i);
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    rst_i = 1'h1;
    msr_rd_i = 1'h0;
    msr_wr_i = 1'h0;
    msr_num_i = '0;
    msr_wdata_i = '0;
    supported_i = 1'h1;
    ts_present_i = 1'h1;
    xmask_i = 64'h4000_0000_0000_0000;
    insn_req_i = 1'h0;
    insn_op_i = LPROF_OP_LOAD;
    insn_addr_i = '0;
    ds_base_i = 64'h100;
    insn_events_i = 6'h3f;
    val_interval_i = 32'h1;
    val_counter_i = 32'h0;
    restore_i = 1'h0;
    restore_addr_i = '0;
    tsc_i = 64'h1234_5678_9abc_def0;
    rows = '{'{64'hffff_ffff_ffff_ffff, 64'h0000_ffff_e000_007e},
             '{64'h0000_0000_2000_0000, 64'h0000_0000_2000_0000},
             '{64'h0000_0000_8000_0000, 64'h0000_0000_8000_0000},
             '{64'hffff_5a3c_4000_0002, 64'h0000_5a3c_4000_0002}};
    repeat (12) @(negedge mclk_i);
    rst_i = 1'h0;
    msr(1'h1, 1'h0, `LPROF_CBADDR_NUM, '0);
    `CHK("cbaddr", 64'h0, msr_rdata_o)
    `CHK("ack", 1'h1, msr_ack_o)
    msr(1'h1, 1'h0, `LPROF_CFG_NUM, '0);
    `CHK("cfg", 64'h0, msr_rdata_o)
    $display("test reset done");
    foreach (rows[i])
    begin
      msr(1'h0, 1'h1, `LPROF_CFG_NUM, rows[i].w);
      msr(1'h1, 1'h0, `LPROF_CFG_NUM, '0);
      `CHK("cfg", rows[i].e, msr_rdata_o)
      // mirrors trail the register by one cycle, so look after the read
      `CHK("continuous_select", rows[i].e[29], continuous_o)
      `CHK("int", rows[i].e[31], thr_int_en_o)
      `CHK("vec", rows[i].e[47:40], thr_vector_o)
    end
    $display("test config rows done");
    msr(1'h0, 1'h1, `LPROF_CBADDR_NUM, 64'h40);
    `CHK("gp", 1'h1, gp_fault_o)
    msr(1'h1, 1'h0, `LPROF_CBADDR_NUM, '0);
    `CHK("cbaddr", 64'h0, msr_rdata_o)
    msr(1'h1, 1'h0, 32'hc000_0107, '0);
    `CHK("gp", 1'h1, gp_fault_o)
    // first four lack the feature, last four lack the mask bit
    for (int k = 0; k < 8; k++)
    begin
      supported_i = k[2];
      xmask_i = {1'h0, ~k[2], 62'h0};
      insn(lprof_op_t'(k[1:0]), 64'h80);
      `CHK("ud", 1'h1, ud_fault_o)
      `CHK("done", 1'h0, insn_done_o)
    end
    supported_i = 1'h1;
    xmask_i = 64'h4000_0000_0000_0000;
    $display("test faults done");
    insn(LPROF_OP_LOAD, 64'h2000);
    `CHK("done", 1'h1, insn_done_o)
    `CHK("active", 1'h1, active_o)
    `CHK("events", 6'h3f, events_o)
    msr(1'h1, 1'h0, `LPROF_CBADDR_NUM, '0);
    `CHK("cbaddr", 64'h2100, msr_rdata_o)
    `CHK("discard", 1'h0, discard_o)
    `CHK("active", 1'h1, active_o)
    // segment base moves; stored linear address must not follow it
    ds_base_i = 64'h300;
    insn(LPROF_OP_STORE, '0);
    `CHK("result", 64'h1e00, insn_result_o)
    `CHK("linear", 64'h2100, cb_linear_o)
    insn(LPROF_OP_INSERT, '0);
    `CHK("store", 1'h1, rec_store_o)
    `CHK("tag", 8'h3c, rec_tag_o)
    `CHK("stamp", tsc_i, rec_stamp_o)
    ts_present_i = 1'h0;
    insn(LPROF_OP_INSERT, '0);
    `CHK("stamp", 64'h0, rec_stamp_o)
    ts_present_i = 1'h1;
    // count 0 then interval 1: record, skip, record
    for (int k = 0; k < 3; k++)
    begin
      insn(LPROF_OP_VALUE, '0);
      `CHK("value", k != 1, rec_store_o)
    end
    $display("test instructions done");
    msr(1'h0, 1'h1, `LPROF_CBADDR_NUM, '0);
    `CHK("discard", 1'h1, discard_o)
    @(negedge mclk_i);
    `CHK("active", 1'h0, active_o)
    `CHK("events", 6'h0, events_o)
    insn(LPROF_OP_STORE, '0);
    `CHK("result", 64'h0, insn_result_o)
    restore_addr_i = 64'h4440;
    restore_i = 1'h1;
    @(negedge mclk_i);
    restore_i = 1'h0;
    msr(1'h1, 1'h0, `LPROF_CBADDR_NUM, '0);
    `CHK("cbaddr", 64'h4440, msr_rdata_o)
    rst_i = 1'h1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'h0;
    msr(1'h1, 1'h0, `LPROF_CFG_NUM, '0);
    `CHK("cfg", 64'h0, msr_rdata_o)
    msr(1'h1, 1'h0, `LPROF_CBADDR_NUM, '0);
    `CHK("cbaddr", 64'h0, msr_rdata_o)
    $display("test stop and second reset done");
    conclude();
  end
endmodule // lprof_ctrl_tb
